/* File: rtl/bus_buffer_pkg.sv */
// Constants for the hot-swap two-wire bus buffer control logic.
// Assumes a 100 MHz reference clock.
package bus_buffer_pkg;
  localparam int unsigned CLK_MHZ         = 100;
  // Initialization time, microseconds
  localparam int unsigned INIT_TIME_US    = 110;
  localparam int unsigned INIT_CYCLES     = INIT_TIME_US * CLK_MHZ;
  // Bus idle window, microseconds: least and most
  localparam int unsigned IDLE_MIN_US     = 50;
  localparam int unsigned IDLE_MAX_US     = 200;
  localparam int unsigned IDLE_MIN_CYCLES = IDLE_MIN_US * CLK_MHZ;
  localparam int unsigned IDLE_MAX_CYCLES = IDLE_MAX_US * CLK_MHZ;
  // Idle time used, chosen inside the window
  localparam int unsigned IDLE_TIME_US    = 105;
  localparam int unsigned IDLE_CYCLES     = IDLE_TIME_US * CLK_MHZ;
  // Enable-to-ready disable time, nanoseconds
  localparam int unsigned READY_DIS_NS    = 30;
  localparam int unsigned READY_DIS_CYC   = READY_DIS_NS * CLK_MHZ / 1000;
  localparam int unsigned CNT_W           = 16;
  localparam int unsigned SYNC_STAGES     = 3;
  // Cycles a released pin is ignored while its synchroniser catches up
  localparam int unsigned RELEASE_HOLD    = SYNC_STAGES + 1;

  typedef enum logic [1:0] {
    ST_OFF     = 2'b00,
    ST_INIT    = 2'b01,
    ST_WAIT    = 2'b11,
    ST_CONNECT = 2'b10
  } conn_state_e;
endpackage

/* File: rtl/pin_sync.sv */
// Three-stage synchroniser for one asynchronous pin level.
// Output changes once stages one and two agree.
`timescale 1ns/1ps
`default_nettype none
module pin_sync
#(
  parameter logic RESET_VAL = 1'b1
)
(
  input  wire logic ref_clk,
  input  wire logic rst_b,
  input  wire logic pin_in,
  output logic      level_out
);
  typedef struct packed
  {
    logic [2:0] sh;
    logic       lvl;
  } sync_s;

  sync_s st_q;
  sync_s st_d;

  always_comb
  begin
    st_d    = st_q;
    st_d.sh = {st_q.sh[1:0], pin_in};
    // Stage 0 only feeds stage 1
    if (st_q.sh[1] == st_q.sh[2])
    begin
      st_d.lvl = st_q.sh[2];
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      st_q <= '{sh: {3{RESET_VAL}}, lvl: RESET_VAL};
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign level_out = st_q.lvl;
endmodule
`default_nettype wire

/* File: rtl/hot_swap_connect.sv */
// Connect control of a hot-swap two-wire bus buffer.
// Bus pins are open-drain: each has input, output and active-low enable.
`timescale 1ns/1ps
`default_nettype none
module hot_swap_connect
  import bus_buffer_pkg::*;
#(
  parameter int unsigned INIT_CNT = INIT_CYCLES,
  parameter int unsigned IDLE_CNT = IDLE_CYCLES
)
(
  input  wire logic ref_clk,
  input  wire logic rst_b,
  input  wire logic enable,
  input  wire logic backplane_data_pin_i,
  output logic      backplane_data_pin_o,
  output logic      backplane_data_pin_oe_b,
  input  wire logic backplane_clock_pin_i,
  output logic      backplane_clock_pin_o,
  output logic      backplane_clock_pin_oe_b,
  input  wire logic card_data_pin_i,
  output logic      card_data_pin_o,
  output logic      card_data_pin_oe_b,
  input  wire logic card_clock_pin_i,
  output logic      card_clock_pin_o,
  output logic      card_clock_pin_oe_b,
  output logic      precharge_on,
  output logic      ready_o,
  output logic      ready_oe_b
);
  import bus_buffer_pkg::*;

  // Sync order: bp data, bp clock, card data, card clock
  logic [3:0] pin_raw;
  logic [3:0] pin_lvl;
  logic       en_lvl;

  assign pin_raw = {card_clock_pin_i, card_data_pin_i,
                    backplane_clock_pin_i, backplane_data_pin_i};

  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_sync
      pin_sync #(.RESET_VAL(1'b1)) u_sync
      (
        .ref_clk   (ref_clk),
        .rst_b     (rst_b),
        .pin_in    (pin_raw[g]),
        .level_out (pin_lvl[g])
      );
    end
  endgenerate

  pin_sync #(.RESET_VAL(1'b0)) u_en_sync
  (
    .ref_clk   (ref_clk),
    .rst_b     (rst_b),
    .pin_in    (enable),
    .level_out (en_lvl)
  );

  typedef struct packed
  {
    conn_state_e st;
    logic [CNT_W-1:0] cnt;
    logic [3:0]  prev;
    logic [3:0][2:0] hold;
    logic        drv_bp_data;
    logic        drv_bp_clk;
    logic        drv_cd_data;
    logic        drv_cd_clk;
    logic        precharge;
    logic        ready;
  } ctl_s;

  ctl_s st_q;
  ctl_s st_d;

  logic       all_high;
  logic       stop_seen;
  logic [3:0] ext_low;
  logic [3:0] drv_now;
  logic [3:0] hold_free;

  assign all_high  = &pin_lvl;
  // Data rises while clock high on the backplane pair
  assign stop_seen = pin_lvl[0] && !st_q.prev[0] && pin_lvl[1] && st_q.prev[1];

  // Drive bits in synchroniser order
  assign drv_now = {st_q.drv_cd_clk, st_q.drv_cd_data,
                    st_q.drv_bp_clk, st_q.drv_bp_data};

  // A just-released pin still shows our own low for a few cycles;
  // without the hold-off the two sides would pull each other forever
  always_comb
  begin
    for (int n = 0; n < 4; n++)
    begin
      hold_free[n] = (st_q.hold[n] == 3'h0);
    end
  end

  // A low that we are not driving ourselves is external
  assign ext_low = ~pin_lvl & ~drv_now & hold_free;

  always_comb
  begin
    st_d      = st_q;
    st_d.prev = pin_lvl;
    case (st_q.st)
      ST_OFF:
      begin
        st_d.cnt = '0;
        if (en_lvl)
        begin
          st_d.st        = ST_INIT;
          st_d.precharge = 1'b1;
        end
      end
      ST_INIT:
      begin
        st_d.cnt = st_q.cnt + CNT_W'(1);
        if (st_q.cnt >= CNT_W'(INIT_CNT - 1))
        begin
          st_d.st  = ST_WAIT;
          st_d.cnt = '0;
        end
      end
      ST_WAIT:
      begin
        // Any low restarts the idle timer, so busy sides delay the join
        if (!all_high)
        begin
          st_d.cnt = '0;
        end
        else if (stop_seen && &pin_lvl[3:2])
        begin
          st_d.st        = ST_CONNECT;
          st_d.precharge = 1'b0;
        end
        else if (st_q.cnt >= CNT_W'(IDLE_CNT - 1))
        begin
          st_d.st        = ST_CONNECT;
          st_d.precharge = 1'b0;
        end
        else
        begin
          st_d.cnt = st_q.cnt + CNT_W'(1);
        end
      end
      ST_CONNECT:
      begin
        st_d.ready = 1'b1;
        // Pull-down follows external lows; released on other side's rise
        st_d.drv_cd_data = ext_low[0];
        st_d.drv_bp_data = ext_low[2];
        st_d.drv_cd_clk  = ext_low[1];
        st_d.drv_bp_clk  = ext_low[3];
      end
      default:
      begin
        st_d.st = ST_OFF;
      end
    endcase
    // Release hold-off: our own low is still in the synchroniser
    for (int n = 0; n < 4; n++)
    begin
      if (drv_now[n])
      begin
        st_d.hold[n] = 3'(RELEASE_HOLD);
      end
      else if (st_q.hold[n] != 3'h0)
      begin
        st_d.hold[n] = st_q.hold[n] - 3'h1;
      end
    end
    if (!en_lvl)
    begin
      st_d.st          = ST_OFF;
      st_d.cnt         = '0;
      st_d.precharge   = 1'b0;
      st_d.ready       = 1'b0;
      st_d.drv_bp_data = 1'b0;
      st_d.drv_bp_clk  = 1'b0;
      st_d.drv_cd_data = 1'b0;
      st_d.drv_cd_clk  = 1'b0;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      st_q <= '{st: ST_OFF, cnt: '0, prev: 4'hF, hold: '0,
                default: 1'b0};
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // Synchronised low stands for a qualified fall
  // Outputs only ever pull low; high is left to pull-ups
  assign backplane_data_pin_o     = 1'b0;
  assign backplane_clock_pin_o    = 1'b0;
  assign card_data_pin_o          = 1'b0;
  assign card_clock_pin_o         = 1'b0;
  assign backplane_data_pin_oe_b  = !st_q.drv_bp_data;
  assign backplane_clock_pin_oe_b = !st_q.drv_bp_clk;
  assign card_data_pin_oe_b       = !st_q.drv_cd_data;
  assign card_clock_pin_oe_b      = !st_q.drv_cd_clk;
  assign precharge_on             = st_q.precharge;
  // Released when ready; pull-down returns as soon as the synchronised enable drops
  assign ready_o                  = 1'b0;
  assign ready_oe_b               = st_q.ready && en_lvl;
endmodule
`default_nettype wire

/* File: test/bus_party.sv */
// Open-drain wires of backplane and card buses.
// Assumes the bench sets ext_low; device enables are active low.
`timescale 1ns/1ps
`default_nettype none
module bus_party
(
  input  wire logic [3:0] ext_low,
  input  wire logic [3:0] dev_oe_b,
  output logic      [3:0] wire_lvl
);
  // Pull-ups on every line, so released lines read high
  assign wire_lvl = ~(ext_low | ~dev_oe_b);
endmodule
`default_nettype wire

/* File: test/hot_swap_connect_asserts.sv */
// Checker on the connect control ports.
// Assumes a bind onto hot_swap_connect; one clock domain.
`timescale 1ns/1ps
`default_nettype none
module hot_swap_connect_asserts
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic enable,
  input wire logic backplane_clock_pin_i,
  input wire logic card_data_pin_i,
  input wire logic backplane_data_pin_o,
  input wire logic backplane_clock_pin_o,
  input wire logic card_data_pin_o,
  input wire logic card_clock_pin_o,
  input wire logic backplane_data_pin_oe_b,
  input wire logic backplane_clock_pin_oe_b,
  input wire logic card_data_pin_oe_b,
  input wire logic card_clock_pin_oe_b,
  input wire logic precharge_on,
  input wire logic ready_o,
  input wire logic ready_oe_b
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  wire logic rel = backplane_data_pin_oe_b & backplane_clock_pin_oe_b
    & card_data_pin_oe_b & card_clock_pin_oe_b;
  // Six samples cover the pin synchroniser
  sequence card_data_ext;
    (ready_oe_b && !card_data_pin_i && card_data_pin_oe_b) [*6];
  endsequence
  sequence bp_clock_ext;
    (ready_oe_b && !backplane_clock_pin_i && backplane_clock_pin_oe_b) [*6];
  endsequence
  AST_RESET: assert property ($rose(rst_b) |-> rel && !precharge_on
    && !ready_oe_b) else $error("active after reset");
  AST_READY_DROP: assert property (!enable [*6] |-> !ready_oe_b)
    else $error("ready not dropped");
  AST_DISCON: assert property (!enable [*8] |-> rel && !precharge_on)
    else $error("not disconnected");
  AST_PRECH: assert property (precharge_on |-> !ready_oe_b)
    else $error("ready during precharge");
  AST_NO_HIGH: assert property (!(backplane_data_pin_o
    | backplane_clock_pin_o | card_data_pin_o | card_clock_pin_o | ready_o))
    else $error("pin driven high");
  AST_READY_CAUSE: assert property ($rose(ready_oe_b)
    |-> $past(precharge_on, 2)) else $error("ready without connect");
  AST_MIRROR_DATA: assert property (card_data_ext
    |-> !backplane_data_pin_oe_b) else $error("data low not mirrored");
  AST_MIRROR_CLOCK: assert property (bp_clock_ext
    |-> !card_clock_pin_oe_b) else $error("clock low not mirrored");
endmodule
`default_nettype wire

/* File: test/hot_swap_connect_tb.sv */
// Bench for the connect control: pins, enable and ready.
// Assumes bus_party resolves the open-drain wires.
`timescale 1ns/1ps
`default_nettype none
`define check(got, exp) \
  begin check_count++; if ((got) !== (exp)) begin n_fail++; \
  $display("[FAIL] %0t got %b", $time, got); end end
module hot_swap_connect_tb;
  localparam int unsigned INIT_N = 20;
  localparam int unsigned IDLE_N = 30;
  logic       ref_clk     = 1'b0;
  logic       rst_b       = 1'b0;
  logic       enable      = 1'b0;
  logic [3:0] ext_low     = 4'h0;
  logic [3:0] v;
  wire  [3:0] lvl;
  wire  [3:0] oe_b;
  wire        pch;
  wire        rdy_b;
  int         n_fail      = 0;
  int         check_count = 0;
  int         cyc         = 0;
  int         seed        = 32'hFC1819E8;
  int         t;
  hot_swap_connect #(.INIT_CNT(INIT_N), .IDLE_CNT(IDLE_N))
    hot_swap_connect_inst
  (
    .ref_clk (ref_clk), .rst_b (rst_b), .enable (enable),
    .backplane_data_pin_i (lvl[0]), .backplane_data_pin_o (),
    .backplane_data_pin_oe_b (oe_b[0]), .backplane_clock_pin_i (lvl[1]),
    .backplane_clock_pin_o (), .backplane_clock_pin_oe_b (oe_b[1]),
    .card_data_pin_i (lvl[2]), .card_data_pin_o (),
    .card_data_pin_oe_b (oe_b[2]), .card_clock_pin_i (lvl[3]),
    .card_clock_pin_o (), .card_clock_pin_oe_b (oe_b[3]),
    .precharge_on (pch), .ready_o (), .ready_oe_b (rdy_b)
  );
  bus_party bus_party_inst
    (.ext_low (ext_low), .dev_oe_b (oe_b), .wire_lvl (lvl));
  always #5 ref_clk = ~ref_clk;
  // Pairs: data 0 with 2, clock 1 with 3
  function automatic logic [3:0] exp_oe_b(input logic [3:0] x);
    return ~{x[1], x[0], x[3], x[2]};
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic drive(input logic en, input logic [3:0] x);
    @(posedge ref_clk);
    enable <= en;
    ext_low <= x;
  endtask
  task automatic wait_ready(input int lim, output int took);
    took = 0;
    while (rdy_b !== 1'b1 && took < lim)
    begin
      tick(1);
      took++;
    end
  endtask
  task automatic final_report();
    $display("checks %0d fails %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      n_fail++;
      final_report();
    end
  end
  initial
  begin
    repeat (4) @(posedge ref_clk);
    rst_b <= 1'b1;
    tick(1);
    `check({oe_b, pch, rdy_b}, 6'h3C)
    drive(1'b1, 4'h0);
    tick(6);
    `check({pch, rdy_b}, 2'h2)
    wait_ready(200, t);
    `check(t, INIT_N + IDLE_N)
    `check({pch, rdy_b}, 2'h1)
    $display("startup test end");
    for (int i = 0; i < 12; i++)
    begin
      v = $random(seed);
      v = (i < 4) ? 4'h1 << i : v & ~{v[1:0], 2'h0};
      drive(1'b1, v);
      tick(8);
      `check(oe_b, exp_oe_b(v))
      drive(1'b1, 4'h0);
      tick(8);
      `check(oe_b, 4'hF)
    end
    $display("mirror test end");
    drive(1'b1, 4'h4);
    tick(8);
    drive(1'b0, 4'h4);
    tick(5);
    `check(rdy_b, 1'b0)
    tick(3);
    `check({oe_b, pch}, 5'h1E)
    $display("disable test end");
    drive(1'b1, 4'h4);
    tick(INIT_N + IDLE_N + 20);
    `check({oe_b, pch, rdy_b}, 6'h3E)
    drive(1'b1, 4'h1);
    tick(5);
    drive(1'b1, 4'h0);
    wait_ready(10, t);
    `check(rdy_b, 1'b1)
    $display("stop test end");
    final_report();
  end
endmodule
bind hot_swap_connect hot_swap_connect_asserts
  hot_swap_connect_asserts_inst (.*);
`default_nettype wire
